// File: logic/ssmc_pkg.sv
// Purpose: shared constants and types for the sync/static memory controller
// Assumes: one clock at 50 MHz, the cpu clock domain
// Notes: waveform pattern is 96 bits, burst beats counted per 32-bit word
package ssmc_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam logic [1:0] RT_NONBURST0 = 2'h0;
  localparam logic [1:0] RT_NONBURST1 = 2'h1;
  localparam logic [1:0] RT_BURST4 = 2'h2;
  localparam logic [1:0] RT_BURST8 = 2'h3;
  localparam int unsigned MRS_GAP_CYC = 3;
  localparam logic [2:0] MRS_GAP = 3'h3;
  localparam logic [2:0] SROM_BURST_LEN = 3'h3;
  localparam int unsigned WAVE_BITS = 96;
  localparam logic [95:0] WAVE_RESET = 96'h0;
  localparam logic [3:0] TRP_RESET = 4'h5;
  localparam logic [3:0] DELAY_RESET = 4'h0;
  localparam int unsigned ROM_ADDR_BIT = 27;

  typedef enum logic [6:0] {
    SS_IDLE = 7'h01,
    SS_MRS = 7'h02,
    SS_STATIC = 7'h04,
    SS_REFRESH = 7'h08,
    SS_PRECH = 7'h10,
    SS_SDRAM = 7'h20,
    SS_WAKE = 7'h40
  } ssmc_state_e;

  typedef struct packed {
    logic clock_enable;
    logic clock_run;
    logic [3:0] static_chip_select_n;
    logic [3:0] dram_row_or_sync_select_n;
    logic sync_row_strobe_n;
    logic sync_column_strobe_n;
    logic write_enable_n;
    logic output_enable_n;
    logic [3:0] byte_mask_column_strobe;
  } ssmc_pins_s;

  localparam ssmc_pins_s PINS_IDLE = '{1'b0, 1'b0, 4'hf, 4'hf,
    1'b1, 1'b1, 1'b1, 1'b1, 4'hf};

  typedef struct packed {
    logic [1:0] static_read_type;
    logic [3:0] first_access_delay;
    logic [3:0] burst_beat_delay;
    logic bus16;
  } ssmc_bank_cfg_s;
endpackage

// File: logic/ssmc_clkdiv.sv
// Purpose: memory clock divider, half or quarter of the cpu clock
// Assumes: i_clk is the cpu clock
// Notes: held stopped while i_run is low
`timescale 1ns/10ps
`default_nettype none
module ssmc_clkdiv
  import ssmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic i_quarter,
  output logic o_mem_clk,
  output logic o_rise
);
  logic [1:0] cnt_reg;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cnt_reg <= 2'h0;
    else if (!i_run)
      cnt_reg <= 2'h0;
    else if (i_quarter)
      cnt_reg <= cnt_reg + 2'h1;
    else
      cnt_reg <= {~cnt_reg[1], 1'b0};
  end

  // R12
  assign o_mem_clk = cnt_reg[1];
  assign o_rise = i_run && (i_quarter ? (cnt_reg == 2'h1) : !cnt_reg[1]);
endmodule
`default_nettype wire

// File: logic/ssmc_ctrl.sv
// Purpose: sdram / sync rom / static burst sequencer
// Assumes: single clock; requests from same-clock logic
// Notes: refresh only between 32-bit words
// Operation
// R1: any reset idles every memory control pin
// R2: refresh breaks static burst only between words
// R3: read type 0/1 non-burst, 2/3 burst
// R4: first delay on aligned beat, burst delay after
// R5: burst4 on 16/32-bit, burst8 on 16-bit
// R6: three memory clocks after rom mode set
// R7: any rom config write issues burst-8 mode set
// R8: precharge counter, bypassed for rom by address
// R9: clock enable high before next activate
// R10: software quiesces and disables banks before reset
// R11: 96-bit column waveform, ones then 01 pattern
// R12: memory clock half or quarter of cpu
// R13: software sets precharge time five or more
// R14: finish command, refresh, resume with first timing
`timescale 1ns/10ps
`default_nettype none
module ssmc_ctrl
  import ssmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_soft_reset,
  input wire logic i_watchdog_reset,
  input wire logic i_quarter_rate,
  input wire ssmc_bank_cfg_s i_bank_cfg,
  input wire logic [3:0] i_ras_precharge_time,
  input wire logic i_sync_rom_config_wr,
  input wire logic [95:0] i_column_strobe_waveform,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic i_is_static,
  input wire logic i_refresh_req,
  input wire logic i_power_down,
  output logic o_req_ready,
  output logic o_word_done,
  output logic o_refresh_done,
  output logic o_rom_burst_ok,
  output logic o_busy,
  output logic o_mrs_issued,
  output logic [2:0] o_mrs_burst_len,
  output logic o_sdram_clock_enable,
  output logic o_sdram_clock_out,
  output logic [3:0] o_static_chip_select_n,
  output logic [3:0] o_dram_row_or_sync_select_n,
  output logic o_sync_row_strobe_n,
  output logic o_sync_column_strobe_n,
  output logic o_write_enable_n,
  output logic o_output_enable_n,
  output logic [3:0] o_byte_mask_column_strobe
);
  ssmc_state_e state_reg;
  ssmc_state_e state_next;
  ssmc_pins_s pins_reg;
  ssmc_pins_s pins_next;
  logic sys_reset;
  logic [3:0] wait_reg;
  logic [3:0] trp_reg;
  logic [2:0] mrs_gap_reg;
  logic mrs_pend_reg;
  logic [2:0] beat_reg;
  logic burst_active_reg;
  logic resume_first_reg;
  logic cke_seen_reg;
  logic mem_rise;
  logic clk_run;
  logic burst_mode;
  logic [2:0] beat_last;
  logic wait_done;
  logic wave_ok;

  // software and watchdog resets act synchronously and clear all state but the gap and precharge counters
  assign sys_reset = i_soft_reset || i_watchdog_reset;

  ssmc_clkdiv u_div (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_run(clk_run),
    .i_quarter(i_quarter_rate),
    .o_mem_clk(o_sdram_clock_out),
    .o_rise(mem_rise)
  );

  assign clk_run = pins_reg.clock_run && !sys_reset; // R1
  assign burst_mode = i_bank_cfg.static_read_type[1]; // R3
  // burst of 8 only legal on 16-bit data
  assign beat_last = (i_bank_cfg.bus16 &&
    i_bank_cfg.static_read_type == RT_BURST8) ? 3'h7 : 3'h3; // R5
  assign wait_done = (wait_reg == 4'h0);

  // an all-ones pattern never enables rom bursts
  always_comb
  begin
    logic seen_zero;
    seen_zero = 1'b0;
    for (int i = 0; i < WAVE_BITS; i++)
      if (!i_column_strobe_waveform[i])
        seen_zero = 1'b1;
    wave_ok = seen_zero;
  end

  always_comb
  begin
    logic p;
    logic seen;
    logic ok;
    p = 1'b0;
    seen = 1'b0;
    ok = 1'b1;
    for (int i = 0; i < WAVE_BITS; i++)
    begin
      if (seen)
      begin
        p = ~p;
        if (i_column_strobe_waveform[i] != p)
          ok = 1'b0;
      end
      else if (!i_column_strobe_waveform[i])
      begin
        seen = 1'b1;
        p = 1'b0;
      end
    end
    o_rom_burst_ok = ok && seen && wave_ok; // R11
  end

  // mode set pending on any config write, even unchanged value
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      mrs_pend_reg <= 1'b0;
    else if (sys_reset)
      mrs_pend_reg <= 1'b0;
    else if (i_sync_rom_config_wr)
      mrs_pend_reg <= 1'b1; // R7
    else if (state_reg == SS_MRS)
      mrs_pend_reg <= 1'b0;
  end

  // gap after mode set counted in memory clock rises
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      mrs_gap_reg <= 3'h0;
    else if (state_reg == SS_MRS)
      mrs_gap_reg <= MRS_GAP; // R6
    else if (mem_rise && mrs_gap_reg != 3'h0)
      mrs_gap_reg <= mrs_gap_reg - 3'h1;
  end

  // precharge counter, skipped for rom by upper address bit
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      trp_reg <= 4'h0;
    else if (state_reg == SS_SDRAM)
      trp_reg <= i_ras_precharge_time; // R8
    else if (mem_rise && trp_reg != 4'h0)
      trp_reg <= trp_reg - 4'h1;
  end

  // clock enable must be seen on a rise before activate
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cke_seen_reg <= 1'b0;
    else if (!pins_reg.clock_enable || sys_reset)
      cke_seen_reg <= 1'b0;
    else if (mem_rise)
      cke_seen_reg <= 1'b1; // R9
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg <= SS_IDLE;
      pins_reg <= PINS_IDLE; // R1
    end
    else if (sys_reset)
    begin
      state_reg <= SS_IDLE;
      pins_reg <= PINS_IDLE; // R1
    end
    else
    begin
      state_reg <= state_next;
      pins_reg <= pins_next;
    end
  end

  // per-beat wait counter and burst bookkeeping
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wait_reg <= DELAY_RESET;
      beat_reg <= 3'h0;
      burst_active_reg <= 1'b0;
      resume_first_reg <= 1'b0;
    end
    else if (sys_reset)
    begin
      wait_reg <= DELAY_RESET;
      beat_reg <= 3'h0;
      burst_active_reg <= 1'b0;
      resume_first_reg <= 1'b0;
    end
    else if (state_next == SS_STATIC && state_reg != SS_STATIC)
    begin
      // aligned to the burst length, or resumed, takes first delay
      if (!burst_mode || (i_addr[4:2] & beat_last) == 3'h0 ||
          resume_first_reg || !burst_active_reg)
        wait_reg <= i_bank_cfg.first_access_delay; // R4 R14
      else
        wait_reg <= i_bank_cfg.burst_beat_delay; // R4
      burst_active_reg <= burst_mode;
      resume_first_reg <= 1'b0;
      beat_reg <= i_addr[4:2] & beat_last;
    end
    else if (state_reg == SS_STATIC && !wait_done)
      wait_reg <= wait_reg - 4'h1;
    else if (state_reg == SS_STATIC && wait_done)
    begin
      beat_reg <= beat_reg + 3'h1;
      if (beat_reg == beat_last)
        burst_active_reg <= 1'b0;
    end
    else if (state_reg == SS_REFRESH && burst_active_reg)
      resume_first_reg <= 1'b1; // R14
  end

  always_comb
  begin
    state_next = state_reg;
    pins_next = pins_reg;
    pins_next.sync_row_strobe_n = 1'b1;
    pins_next.sync_column_strobe_n = 1'b1;
    pins_next.write_enable_n = 1'b1;
    case (state_reg)
      SS_IDLE:
      begin
        pins_next.static_chip_select_n = 4'hf;
        pins_next.output_enable_n = 1'b1;
        pins_next.byte_mask_column_strobe = 4'hf;
        pins_next.dram_row_or_sync_select_n = 4'hf;
        pins_next.clock_run = 1'b1;
        if (i_power_down)
        begin
          pins_next.clock_enable = 1'b0;
          pins_next.clock_run = 1'b0;
        end
        else if (!pins_reg.clock_enable)
        begin
          pins_next.clock_enable = 1'b1; // R9
          state_next = SS_WAKE;
        end
        else if (mrs_pend_reg && mrs_gap_reg == 3'h0)
          state_next = SS_MRS;
        else if (i_refresh_req)
          state_next = SS_REFRESH; // R2
        else if (i_req && i_is_static)
          state_next = SS_STATIC;
        else if (i_req && mrs_gap_reg == 3'h0)
          state_next = SS_PRECH; // R6
      end
      SS_WAKE:
        if (cke_seen_reg)
          state_next = SS_IDLE; // R9
      SS_MRS:
      begin
        pins_next.dram_row_or_sync_select_n = 4'he;
        pins_next.sync_row_strobe_n = 1'b0;
        pins_next.sync_column_strobe_n = 1'b0;
        pins_next.write_enable_n = 1'b0;
        state_next = SS_IDLE; // R7
      end
      SS_REFRESH:
        state_next = SS_IDLE;
      SS_PRECH:
        // rom accesses ignore the sdram precharge counter
        if (i_addr[ROM_ADDR_BIT] || trp_reg == 4'h0)
          state_next = SS_SDRAM; // R8
      SS_SDRAM:
      begin
        if (cke_seen_reg)
        begin
          pins_next.dram_row_or_sync_select_n = 4'he;
          pins_next.sync_row_strobe_n = 1'b0; // R9
          state_next = SS_IDLE;
        end
      end
      SS_STATIC:
      begin
        pins_next.static_chip_select_n = 4'he;
        pins_next.output_enable_n = 1'b0;
        pins_next.byte_mask_column_strobe = 4'h0;
        if (wait_done)
          state_next = SS_IDLE; // R2 R14
      end
      default:
        state_next = SS_IDLE;
    endcase
  end

  assign o_sdram_clock_enable = pins_reg.clock_enable;
  assign o_static_chip_select_n = pins_reg.static_chip_select_n;
  assign o_dram_row_or_sync_select_n = pins_reg.dram_row_or_sync_select_n;
  assign o_sync_row_strobe_n = pins_reg.sync_row_strobe_n;
  assign o_sync_column_strobe_n = pins_reg.sync_column_strobe_n;
  assign o_write_enable_n = pins_reg.write_enable_n;
  assign o_output_enable_n = pins_reg.output_enable_n;
  assign o_byte_mask_column_strobe = pins_reg.byte_mask_column_strobe;
  assign o_mrs_issued = (state_reg == SS_MRS);
  assign o_mrs_burst_len = SROM_BURST_LEN; // R7
  assign o_req_ready = (state_reg == SS_IDLE) && !sys_reset;
  assign o_word_done = (state_reg == SS_STATIC) && wait_done;
  assign o_refresh_done = (state_reg == SS_REFRESH);
  assign o_busy = (state_reg != SS_IDLE);
endmodule
`default_nettype wire

// File: test/ssmc_ctrl_props.sv
// Purpose: port checks on the memory sequencer
// Assumes: rate input changes only while reset is low
// Notes: waveform bit 0 is the first strobe slot
`timescale 1ns/10ps
`default_nettype none
module ssmc_ctrl_props
  import ssmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_soft_reset,
  input wire logic i_watchdog_reset,
  input wire logic i_quarter_rate,
  input wire logic i_sync_rom_config_wr,
  input wire logic [95:0] i_column_strobe_waveform,
  input wire logic o_rom_burst_ok,
  input wire logic o_word_done,
  input wire logic o_refresh_done,
  input wire logic o_mrs_issued,
  input wire logic [2:0] o_mrs_burst_len,
  input wire logic o_sdram_clock_enable,
  input wire logic o_sdram_clock_out,
  input wire logic [3:0] o_static_chip_select_n,
  input wire logic [3:0] o_dram_row_or_sync_select_n,
  input wire logic o_sync_row_strobe_n,
  input wire logic o_sync_column_strobe_n,
  input wire logic o_write_enable_n,
  input wire logic o_output_enable_n,
  input wire logic [3:0] o_byte_mask_column_strobe
);
  logic ok;
  wire logic srst = i_soft_reset || i_watchdog_reset;
  wire logic act = !o_sync_row_strobe_n && o_sync_column_strobe_n &&
    o_write_enable_n;
  wire logic quiet = !o_sdram_clock_enable && !o_sdram_clock_out &&
    (&o_static_chip_select_n) && (&o_dram_row_or_sync_select_n) &&
    o_sync_row_strobe_n && o_sync_column_strobe_n && o_write_enable_n &&
    o_output_enable_n && (&o_byte_mask_column_strobe);
  // first zero starts the 0,1 run up to the top bit
  always_comb
  begin
    int k;
    k = 96;
    ok = 1'b1;
    for (int j = 0; j < 96; j++)
      if (k == 96 && !i_column_strobe_waveform[j])
        k = j;
      else if (k < 96 && i_column_strobe_waveform[j] != ((j - k) % 2 == 1))
        ok = 1'b0;
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  a_reset_pins_idle: assert property (srst |=> quiet)
    else $error("memory pins active after reset");
  a_mrs_len_eight: assert property (
    o_mrs_issued |-> o_mrs_burst_len == 3'h3)
    else $error("mode set without burst of eight");
  a_cfg_write_mrs: assert property (
    i_sync_rom_config_wr |-> ##[1:60] o_mrs_issued)
    else $error("config write gave no mode set");
  a_mrs_gap_held: assert property (
    o_mrs_issued |-> ##3
      (o_sync_row_strobe_n && o_sync_column_strobe_n) [*3])
    else $error("command too soon after mode set");
  a_refresh_word_gap: assert property (
    o_refresh_done |-> &o_static_chip_select_n)
    else $error("refresh inside a static word");
  a_cke_before_act: assert property (
    act |-> o_sdram_clock_enable && $past(o_sdram_clock_enable, 2))
    else $error("activate without clock enable");
  a_rom_burst_flag: assert property (o_rom_burst_ok == ok)
    else $error("burst flag wrong for waveform");
  a_half_rate_clk: assert property (
    !i_quarter_rate && $rose(o_sdram_clock_out) |=> !o_sdram_clock_out)
    else $error("half rate clock wrong");
  a_quarter_rate_clk: assert property (
    disable iff (!i_reset_n || srst)
    i_quarter_rate && $rose(o_sdram_clock_out) |=>
      o_sdram_clock_out ##1 !o_sdram_clock_out)
    else $error("quarter rate clock wrong");
  c_mrs: cover property (o_mrs_issued);
  c_refresh: cover property (o_refresh_done);
  c_word: cover property (o_word_done);
endmodule
`default_nettype wire

// File: test/ssmc_mem_model.sv
// Purpose: behavioural sync memory beyond the pins
// Assumes: commands sampled on memory clock rises
// Notes: flags misuse only, no data is modelled
`timescale 1ns/10ps
`default_nettype none
module ssmc_mem_model
  import ssmc_pkg::*;
(
  input wire logic i_mem_clk,
  input wire logic i_reset_n,
  input wire ssmc_pins_s i_pins,
  output logic o_fault
);
  logic [1:0] gap_reg;
  logic cke_reg;
  wire logic sel = ~&i_pins.dram_row_or_sync_select_n;
  wire logic ras = !i_pins.sync_row_strobe_n;
  wire logic cas = !i_pins.sync_column_strobe_n;
  wire logic we = !i_pins.write_enable_n;
  always_ff @(posedge i_mem_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      gap_reg <= 2'h0;
      cke_reg <= 1'b0;
      o_fault <= 1'b0;
    end
    else
    begin
      cke_reg <= i_pins.clock_enable;
      if (sel && ras && cas && we)
        gap_reg <= 2'h2;
      else if (gap_reg != 2'h0)
        gap_reg <= gap_reg - 2'h1;
      if (sel && (ras || cas || we) && gap_reg != 2'h0)
        o_fault <= 1'b1;
      // device needs clock enable seen on the rise before activate
      if (sel && ras && !cas && !we && !cke_reg)
        o_fault <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: test/ssmc_ctrl_tb.sv
// Purpose: directed run of the memory sequencer
// Assumes: inputs driven on falling edges
// Notes: latencies compared as differences, fixed overhead cancels
`timescale 1ns/10ps
`default_nettype none
module ssmc_ctrl_tb
  import ssmc_pkg::*;
;
  localparam int FD = 6;
  localparam int BD = 2;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_soft_reset = 1'b0;
  logic i_watchdog_reset = 1'b0;
  logic i_quarter_rate = 1'b0;
  ssmc_bank_cfg_s i_bank_cfg = '{2'h0, 4'h6, 4'h2, 1'b0};
  logic [3:0] i_ras_precharge_time = 4'h5;
  logic i_sync_rom_config_wr = 1'b0;
  logic [95:0] i_column_strobe_waveform = 96'h0;
  logic i_req = 1'b0;
  logic i_is_static = 1'b0;
  logic i_refresh_req = 1'b0;
  logic i_power_down = 1'b0;
  logic [31:0] i_addr = 32'h0;
  logic o_req_ready, o_word_done, o_refresh_done, o_rom_burst_ok;
  logic o_busy, o_mrs_issued, o_sdram_clock_enable, o_sdram_clock_out;
  logic o_sync_row_strobe_n, o_sync_column_strobe_n;
  logic o_write_enable_n, o_output_enable_n, mem_fault;
  logic [2:0] o_mrs_burst_len;
  logic [3:0] o_static_chip_select_n, o_dram_row_or_sync_select_n;
  logic [3:0] o_byte_mask_column_strobe;
  int bad_count = 0;
  int total_checks = 0;
  int lat, ref_lat, la, lb;
  int lq [4];
  logic [11:0] rows [10] = '{12'h100, 12'h504, 12'h900, 12'h804,
    12'h910, 12'hf00, 12'he0c, 12'he10, 12'hf20, 12'hd10};
  ssmc_pins_s pins;
  wire logic [2:0] evt = {o_req_ready, o_refresh_done, o_mrs_issued};
  assign pins = '{o_sdram_clock_enable, o_sdram_clock_out,
    o_static_chip_select_n, o_dram_row_or_sync_select_n,
    o_sync_row_strobe_n, o_sync_column_strobe_n, o_write_enable_n,
    o_output_enable_n, o_byte_mask_column_strobe};
  always #10 i_clk = ~i_clk;
  ssmc_ctrl u_ssmc_ctrl (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_soft_reset(i_soft_reset),
    .i_watchdog_reset(i_watchdog_reset),
    .i_quarter_rate(i_quarter_rate),
    .i_bank_cfg(i_bank_cfg),
    .i_ras_precharge_time(i_ras_precharge_time),
    .i_sync_rom_config_wr(i_sync_rom_config_wr),
    .i_column_strobe_waveform(i_column_strobe_waveform),
    .i_req(i_req),
    .i_addr(i_addr),
    .i_is_static(i_is_static),
    .i_refresh_req(i_refresh_req),
    .i_power_down(i_power_down),
    .o_req_ready(o_req_ready),
    .o_word_done(o_word_done),
    .o_refresh_done(o_refresh_done),
    .o_rom_burst_ok(o_rom_burst_ok),
    .o_busy(o_busy),
    .o_mrs_issued(o_mrs_issued),
    .o_mrs_burst_len(o_mrs_burst_len),
    .o_sdram_clock_enable(o_sdram_clock_enable),
    .o_sdram_clock_out(o_sdram_clock_out),
    .o_static_chip_select_n(o_static_chip_select_n),
    .o_dram_row_or_sync_select_n(o_dram_row_or_sync_select_n),
    .o_sync_row_strobe_n(o_sync_row_strobe_n),
    .o_sync_column_strobe_n(o_sync_column_strobe_n),
    .o_write_enable_n(o_write_enable_n),
    .o_output_enable_n(o_output_enable_n),
    .o_byte_mask_column_strobe(o_byte_mask_column_strobe)
  );
  ssmc_mem_model u_ssmc_mem_model (.i_mem_clk(o_sdram_clock_out),
    .i_reset_n(i_reset_n), .i_pins(pins), .o_fault(mem_fault));
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail();
    bad_count++;
    give_verdict();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_for(input int s);
    int n;
    n = 0;
    while (evt[s] !== 1'b1)
    begin
      @(negedge i_clk);
      n++;
      if (n > 300)
        fail();
    end
  endtask
  // request held until word done or until the activate shows
  task automatic access(input logic [31:0] a, input logic st,
    input logic rf, output int lt);
    int n;
    n = 0;
    lt = 0;
    @(negedge i_clk);
    i_addr = a;
    i_is_static = st;
    i_req = 1'b1;
    while (lt == 0)
    begin
      @(negedge i_clk);
      n++;
      if (rf && n == 2)
        i_refresh_req = 1'b1;
      // a wake-up may delay the take, so never drop early
      if (st ? o_word_done === 1'b1 : (o_sync_row_strobe_n === 1'b0 &&
          o_sync_column_strobe_n === 1'b1))
        lt = n;
      if (lt != 0)
        i_req = 1'b0;
      if (n > 300)
        fail();
    end
  endtask
  initial
  begin
    repeat (4) @(negedge i_clk);
    check(pins, PINS_IDLE);
    i_reset_n = 1'b1;
    wait_for(2);
    repeat (2)
    begin
      i_sync_rom_config_wr = 1'b1;
      @(negedge i_clk);
      i_sync_rom_config_wr = 1'b0;
      wait_for(0);
      check(o_mrs_burst_len, 3'h3);
      wait_for(2);
    end
    i_column_strobe_waveform = {{22{4'ha}}, 8'hfe};
    #1 check(o_rom_burst_ok, 1'b0);
    i_column_strobe_waveform = {{22{4'ha}}, 8'hff};
    #1 check(o_rom_burst_ok, 1'b1);
    foreach (rows[i])
    begin
      i_bank_cfg.static_read_type = rows[i][11:10];
      i_bank_cfg.bus16 = rows[i][9];
      access({24'h0, rows[i][7:0]}, 1'b1, 1'b0, lat);
      if (i == 0)
        ref_lat = lat;
      check(lat, rows[i][8] ? ref_lat : ref_lat - FD + BD);
    end
    i_bank_cfg.static_read_type = RT_BURST4;
    i_bank_cfg.bus16 = 1'b0;
    access(32'h0, 1'b1, 1'b1, la);
    check(la, ref_lat);
    wait_for(1);
    i_refresh_req = 1'b0;
    access(32'h4, 1'b1, 1'b0, lb);
    check(lb, ref_lat);
    for (int t = 0; t < 4; t++)
    begin
      i_ras_precharge_time = t[0] ? 4'hf : 4'h5;
      access({4'h0, t[1], 27'h0}, 1'b0, 1'b0, la);
      access({4'h0, t[1], 27'h0}, 1'b0, 1'b0, lb);
      lq[t] = la + lb;
    end
    check(lq[1] > lq[0], 1'b1);
    check(lq[3], lq[2]);
    i_power_down = 1'b1;
    repeat (20) @(negedge i_clk);
    check(o_sdram_clock_enable, 1'b0);
    i_power_down = 1'b0;
    access(32'h0, 1'b0, 1'b0, la);
    check(o_sdram_clock_enable, 1'b1);
    for (int r = 0; r < 2; r++)
    begin
      i_is_static = 1'b1;
      i_req = r[0];
      repeat (2) @(negedge i_clk);
      i_soft_reset = !r[0];
      i_watchdog_reset = r[0];
      @(negedge i_clk);
      check(pins, PINS_IDLE);
      check(o_busy, 1'b0);
      {i_req, i_soft_reset, i_watchdog_reset} = 3'h0;
      wait_for(2);
    end
    i_reset_n = 1'b0;
    i_quarter_rate = 1'b1;
    @(negedge i_clk);
    i_reset_n = 1'b1;
    wait_for(2);
    access(32'h0, 1'b0, 1'b0, la);
    check(mem_fault, 1'b0);
    give_verdict();
  end
endmodule
bind ssmc_ctrl ssmc_ctrl_props u_ssmc_ctrl_props (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_soft_reset(i_soft_reset),
  .i_watchdog_reset(i_watchdog_reset),
  .i_quarter_rate(i_quarter_rate),
  .i_sync_rom_config_wr(i_sync_rom_config_wr),
  .i_column_strobe_waveform(i_column_strobe_waveform),
  .o_rom_burst_ok(o_rom_burst_ok),
  .o_word_done(o_word_done),
  .o_refresh_done(o_refresh_done),
  .o_mrs_issued(o_mrs_issued),
  .o_mrs_burst_len(o_mrs_burst_len),
  .o_sdram_clock_enable(o_sdram_clock_enable),
  .o_sdram_clock_out(o_sdram_clock_out),
  .o_static_chip_select_n(o_static_chip_select_n),
  .o_dram_row_or_sync_select_n(o_dram_row_or_sync_select_n),
  .o_sync_row_strobe_n(o_sync_row_strobe_n),
  .o_sync_column_strobe_n(o_sync_column_strobe_n),
  .o_write_enable_n(o_write_enable_n),
  .o_output_enable_n(o_output_enable_n),
  .o_byte_mask_column_strobe(o_byte_mask_column_strobe)
);
`default_nettype wire
